//--- core/anp_cfg.svh
// register map, field positions and reset values of the next page register bank
// included by the register module and the test bench; definitions only
`ifndef ANP_CFG_SVH
`define ANP_CFG_SVH

// management addresses
`define ANP_REG_EXP 5'h06
`define ANP_REG_NPTX 5'h07
`define ANP_REG_LPNP 5'h08
`define ANP_REG_CFG 5'h10
`define ANP_REG_ST2 5'h11
`define ANP_REG_EVEN 5'h12
`define ANP_REG_EVCH 5'h13
`define ANP_REG_IND 5'h14
`define ANP_REG_TXC 5'h1e
`define ANP_REG_PS_LO 5'h10

// expansion register bits
`define ANP_EXP_BP 5
`define ANP_EXP_PDF 4
`define ANP_EXP_LPNPA 3
`define ANP_EXP_NPA 2
`define ANP_EXP_PRX 1
`define ANP_EXP_LPAN 0

// next page transmit fields
`define ANP_NP_NP 15
`define ANP_NP_RSV 14
`define ANP_NP_MP 13
`define ANP_NP_ACK2 12
`define ANP_NP_TOG 11
`define ANP_NPTX_RST 16'h2001
`define ANP_NPTX_WMASK 16'hb7ff
`define ANP_LPNP_RST 16'h0000

// port configuration fields
`define ANP_CFG_ALT 1
`define ANP_CFG_TXDIS 13
`define ANP_CFG_RST 16'h0080
`define ANP_CFG_WMASK 16'h7fa2
`define ANP_PLAIN_RST 16'h0000

// serial frame
`define ANP_PRE_ONES 6'h20
`define ANP_OP_RD 2'h2
`define ANP_OP_WR 2'h1
`define ANP_DATA_BITS 6'h10

`endif

//--- core/anp_pkg.sv
// types shared by the next page register bank
// constants live in anp_cfg.svh
package anp_pkg;

  typedef logic [15:0] anp_word_t;
  typedef logic [4:0] anp_addr_t;

  typedef enum logic [2:0] {
    ANP_PRE,
    ANP_ST,
    ANP_HDR,
    ANP_TA,
    ANP_RDATA,
    ANP_WDATA
  } anp_mdio_state_e;

endpackage : anp_pkg

//--- core/anp_regs.sv
// management register bank for the auto-negotiation next page exchange
// assumes: mdc/mdio are asynchronous pins, engine signals are on clk
`timescale 1ns/100ps
`include "anp_cfg.svh"

// What this block does
// - expansion bit 4 latches a parallel detection fault until read; resets 0.
// - expansion bit 3 shows partner next page ability; read-only, resets 0.
// - expansion bit 2 always reads 1, local device is next page able.
// - page received latches 1; word goes to base page or register 8.
// - reading clears page received; alternate mode also clears on page_rx low or tx off.
// - expansion bit 0 shows partner auto-negotiation ability; read-only, resets 0.
// - transmit bit 15 next page, read/write, resets 0; 1 means more pages.
// - transmit bit 13 message page, read/write, resets 1.
// - transmit bit 12 acknowledge 2, read/write, resets 0.
// - transmit toggle resets 0, holds inverse of last transmitted toggle.
// - transmit code field, 11 bits read/write, resets to one.
// - receive bit 15 shows partner has more next pages; resets 0.
// - receive bit 14 shows partner acknowledged our code word.
// - receive bit 13 shows partner message page format.
// - receive bit 12 partner complies, bit 11 partner toggle.
// - receive code field 11 bits read-only, resets to zero.
// - addresses 16-20 and 30 decode product registers; 21-31 otherwise reserved.
// - alternate next page enable bit resets 0, gates base page and extra clears.
module anp_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic page_rx_stb,
  input wire logic page_is_next,
  input wire logic [15:0] rx_code_word,
  input wire logic pd_fault_stb,
  input wire logic lp_np_able,
  input wire logic lp_an_able,
  input wire logic base_page,
  input wire logic mr_page_rx,
  input wire logic an_tx_disable,
  input wire logic tx_word_stb,
  input wire logic tx_toggle_sent,
  input wire logic [15:0] sec_status_in,
  input wire logic [15:0] evt_change_in,
  output logic [15:0] np_tx_word,
  output logic [15:0] lp_base_word,
  output logic alt_next_page_enable,
  output logic tx_path_disable,
  output logic [15:0] event_enable_word,
  output logic [15:0] indicator_cfg_word,
  output logic [15:0] tx_ctrl_word
);

  // owned addresses; 0-5 and 9-15 belong to a sibling block and stay undriven
  function automatic logic is_mine(input anp_pkg::anp_addr_t a);
    is_mine = (a == `ANP_REG_EXP) || (a == `ANP_REG_NPTX) || (a == `ANP_REG_LPNP) ||
              (a >= `ANP_REG_PS_LO);
  endfunction : is_mine

  logic [1:0] pin_q;
  logic mdc_q;
  logic mdio_q;
  logic mdc_d_r;
  logic mdc_rise;
  anp_pkg::anp_mdio_state_e st_r;
  logic [5:0] cnt_r;
  logic [11:0] hdr_r;
  logic [15:0] sh_r;
  logic rd_go;
  logic wr_go;
  logic rd_act_r;
  anp_pkg::anp_addr_t reg_a;
  anp_pkg::anp_addr_t hdr_reg;
  logic [15:0] np_tx_r;
  logic [15:0] lpnp_r;
  logic [15:0] lpbase_r;
  logic [15:0] cfg_r;
  logic [15:0] even_r;
  logic [15:0] ind_r;
  logic [15:0] txc_r;
  logic pdf_r;
  logic prx_r;
  logic bp_r;
  logic lpnpa_r;
  logic lpan_r;
  logic [15:0] exp_word;
  logic [15:0] rd_word;
  logic exp_rd;

  anp_sync #(.W(2)) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .d({mdc, mdio_i}),
    .q(pin_q)
  );
  assign mdc_q = pin_q[1];
  assign mdio_q = pin_q[0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mdc_d_r <= 1'b0;
    end else if (ce) begin
      mdc_d_r <= mdc_q;
    end
  end
  assign mdc_rise = ce && mdc_q && !mdc_d_r;

  // header is {op[1:0], phy[4:0], reg[4:0]}
  // at the last register bit hdr_r[10:0] holds op, phy and the upper register bits
  assign reg_a = hdr_r[4:0];
  assign hdr_reg = {hdr_r[3:0], mdio_q};
  assign rd_go = mdc_rise && (st_r == anp_pkg::ANP_HDR) && (cnt_r == 6'h0b) &&
                 (hdr_r[10:4] == {`ANP_OP_RD, PHY_ADDR}) && is_mine(hdr_reg);
  assign wr_go = mdc_rise && (st_r == anp_pkg::ANP_WDATA) && (cnt_r == 6'h0f) &&
                 (hdr_r[11:5] == {`ANP_OP_WR, PHY_ADDR});
  assign exp_rd = rd_go && (hdr_reg == `ANP_REG_EXP);

  // frame sequencer; a preamble must precede every frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= anp_pkg::ANP_PRE;
      cnt_r <= 6'h00;
      hdr_r <= 12'h000;
      sh_r <= 16'h0000;
      rd_act_r <= 1'b0;
    end else if (mdc_rise) begin
      case (st_r)
        anp_pkg::ANP_PRE: begin
          if (mdio_q) begin
            cnt_r <= (cnt_r == `ANP_PRE_ONES) ? cnt_r : cnt_r + 6'h01;
          end else begin
            cnt_r <= 6'h00;
            if (cnt_r == `ANP_PRE_ONES) begin
              st_r <= anp_pkg::ANP_ST;
            end
          end
        end
        anp_pkg::ANP_ST: begin
          cnt_r <= 6'h00;
          st_r <= mdio_q ? anp_pkg::ANP_HDR : anp_pkg::ANP_PRE;
        end
        anp_pkg::ANP_HDR: begin
          hdr_r <= {hdr_r[10:0], mdio_q};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'h0b) begin
            cnt_r <= 6'h00;
            st_r <= anp_pkg::ANP_TA;
            rd_act_r <= rd_go;
            sh_r <= rd_word;
          end
        end
        anp_pkg::ANP_TA: begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'h01) begin
            cnt_r <= 6'h00;
            st_r <= rd_act_r ? anp_pkg::ANP_RDATA : anp_pkg::ANP_WDATA;
          end
        end
        anp_pkg::ANP_RDATA: begin
          sh_r <= {sh_r[14:0], 1'b0};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'h0f) begin
            cnt_r <= 6'h00;
            rd_act_r <= 1'b0;
            st_r <= anp_pkg::ANP_PRE;
          end
        end
        anp_pkg::ANP_WDATA: begin
          sh_r <= {sh_r[14:0], mdio_q};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'h0f) begin
            cnt_r <= 6'h00;
            st_r <= anp_pkg::ANP_PRE;
          end
        end
        default: begin
          st_r <= anp_pkg::ANP_PRE;
          cnt_r <= 6'h00;
        end
      endcase
    end
  end

  // drive 0 in the second turnaround bit, then data msb first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      if (st_r == anp_pkg::ANP_TA && cnt_r == 6'h00 && rd_act_r) begin
        mdio_o <= 1'b0;
        mdio_oe <= 1'b1;
      end else if (st_r == anp_pkg::ANP_TA && rd_act_r) begin
        mdio_o <= sh_r[15];
      end else if (st_r == anp_pkg::ANP_RDATA && cnt_r != 6'h0f) begin
        mdio_o <= sh_r[14];
      end else begin
        mdio_o <= 1'b0;
        mdio_oe <= 1'b0;
      end
    end
  end

  always_comb begin
    exp_word = 16'h0000;
    exp_word[`ANP_EXP_BP] = bp_r;
    exp_word[`ANP_EXP_PDF] = pdf_r;
    exp_word[`ANP_EXP_LPNPA] = lpnpa_r;
    exp_word[`ANP_EXP_NPA] = 1'b1;
    exp_word[`ANP_EXP_PRX] = prx_r;
    exp_word[`ANP_EXP_LPAN] = lpan_r;
  end

  // reserved product addresses read zero
  always_comb begin
    case (hdr_reg)
      `ANP_REG_EXP: rd_word = exp_word;
      `ANP_REG_NPTX: rd_word = np_tx_r;
      `ANP_REG_LPNP: rd_word = lpnp_r;
      `ANP_REG_CFG: rd_word = cfg_r;
      `ANP_REG_ST2: rd_word = sec_status_in;
      `ANP_REG_EVEN: rd_word = even_r;
      `ANP_REG_EVCH: rd_word = evt_change_in;
      `ANP_REG_IND: rd_word = ind_r;
      `ANP_REG_TXC: rd_word = txc_r;
      default: rd_word = 16'h0000;
    endcase
  end

  // latched-high bits: set beats a clearing read in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pdf_r <= 1'b0;
      prx_r <= 1'b0;
      bp_r <= 1'b0;
    end else if (ce) begin
      if (pd_fault_stb) begin
        pdf_r <= 1'b1;
      end else if (exp_rd) begin
        pdf_r <= 1'b0;
      end
      if (page_rx_stb) begin
        prx_r <= 1'b1;
      end else if (exp_rd || (cfg_r[`ANP_CFG_ALT] && (!mr_page_rx || an_tx_disable))) begin
        prx_r <= 1'b0;
      end
      if (cfg_r[`ANP_CFG_ALT] && base_page) begin
        bp_r <= 1'b1;
      end else if (exp_rd) begin
        bp_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lpnpa_r <= 1'b0;
      lpan_r <= 1'b0;
    end else if (ce) begin
      lpnpa_r <= lp_np_able;
      lpan_r <= lp_an_able;
    end
  end

  // received page words
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lpnp_r <= `ANP_LPNP_RST;
      lpbase_r <= `ANP_PLAIN_RST;
    end else if (ce && page_rx_stb) begin
      if (page_is_next) begin
        lpnp_r <= rx_code_word;
      end else begin
        lpbase_r <= rx_code_word;
      end
    end
  end

  // toggle is engine-owned; software cannot write it, bit 14 stays 0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      np_tx_r <= `ANP_NPTX_RST;
    end else if (ce) begin
      if (wr_go && reg_a == `ANP_REG_NPTX) begin
        np_tx_r[15:12] <= {sh_r[14], 1'b0, sh_r[12:11]};
        np_tx_r[10:0] <= {sh_r[9:0], mdio_q};
      end
      if (tx_word_stb) begin
        np_tx_r[`ANP_NP_TOG] <= !tx_toggle_sent;
      end
    end
  end

  // write data is {sh_r[14:0], mdio_q} at the last data edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= `ANP_CFG_RST;
      even_r <= `ANP_PLAIN_RST;
      ind_r <= `ANP_PLAIN_RST;
      txc_r <= `ANP_PLAIN_RST;
    end else if (ce && wr_go) begin
      case (reg_a)
        `ANP_REG_CFG: cfg_r <= {sh_r[14:0], mdio_q} & `ANP_CFG_WMASK;
        `ANP_REG_EVEN: even_r <= {sh_r[14:0], mdio_q};
        `ANP_REG_IND: ind_r <= {sh_r[14:0], mdio_q};
        `ANP_REG_TXC: txc_r <= {sh_r[14:0], mdio_q};
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  assign np_tx_word = np_tx_r;
  assign lp_base_word = lpbase_r;
  assign alt_next_page_enable = cfg_r[`ANP_CFG_ALT];
  assign tx_path_disable = cfg_r[`ANP_CFG_TXDIS];
  assign event_enable_word = even_r;
  assign indicator_cfg_word = ind_r;
  assign tx_ctrl_word = txc_r;

  sequence s_exp_read_quiet;
    exp_rd && !page_rx_stb;
  endsequence

  property p_pdf_set;
    @(posedge clk) disable iff (!rst_b) (ce && pd_fault_stb) |=> pdf_r ##1 (pdf_r || $past(exp_rd));
  endproperty
  a_pdf_set: assert property (p_pdf_set) else $error("fault flag not latched");

  property p_lpnpa;
    @(posedge clk) disable iff (!rst_b) ce |=> exp_word[`ANP_EXP_LPNPA] == $past(lp_np_able);
  endproperty
  a_lpnpa: assert property (p_lpnpa) else $error("partner next page able wrong");

  property p_npa;
    @(posedge clk) disable iff (!rst_b) exp_rd |=> sh_r[`ANP_EXP_NPA] && sh_r[15:6] == 10'h000;
  endproperty
  a_npa: assert property (p_npa) else $error("local next page able not one");

  property p_page_store;
    @(posedge clk) disable iff (!rst_b) (ce && page_rx_stb && page_is_next)
      |=> prx_r && lpnp_r == $past(rx_code_word);
  endproperty
  a_page_store: assert property (p_page_store) else $error("next page not stored");

  property p_prx_clear;
    @(posedge clk) disable iff (!rst_b) s_exp_read_quiet |=> !prx_r;
  endproperty
  a_prx_clear: assert property (p_prx_clear) else $error("page received not cleared");

  property p_rsv14;
    @(posedge clk) disable iff (!rst_b) !np_tx_word[`ANP_NP_RSV];
  endproperty
  a_rsv14: assert property (p_rsv14) else $error("reserved transmit bit set");

  property p_toggle;
    @(posedge clk) disable iff (!rst_b) (ce && tx_word_stb)
      |=> np_tx_word[`ANP_NP_TOG] == !$past(tx_toggle_sent);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not inverted");

  property p_bp_gate;
    @(posedge clk) disable iff (!rst_b) (ce && !alt_next_page_enable && !bp_r) |=> !bp_r;
  endproperty
  a_bp_gate: assert property (p_bp_gate) else $error("base page set while disabled");

  property p_rsv_read;
    @(posedge clk) disable iff (!rst_b)
      (rd_go && hdr_reg > `ANP_REG_IND && hdr_reg != `ANP_REG_TXC)
      |=> sh_r == 16'h0000;
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved address not zero");

endmodule : anp_regs

//--- core/anp_sync.sv
// two flip-flop synchroniser for pin-level inputs
// assumes the input is a level that is slow against clk
`timescale 1ns/100ps
module anp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds the second stage only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : anp_sync

//--- verification/autoneg_next_page_regs_test.sv
// self-checking bench for the next page register bank, management pins and engine side
// assumes a pull-up on mdio and ce held high throughout
`timescale 1ns/100ps
`include "anp_cfg.svh"
module autoneg_next_page_regs_test;
  logic clk = 0, rst_b = 0, mdc = 0, h_en = 0, h_d = 1, mdio_w;
  logic page_rx_stb = 0, page_is_next = 0, pd_fault_stb = 0, lp_np_able = 0, lp_an_able = 0;
  logic mr_page_rx = 1, an_tx_disable = 0, tx_word_stb = 0, tx_toggle_sent = 0;
  logic [15:0] rx_code_word = 0, sec_status_in = 0, evt_change_in = 0, rd, v, e;
  logic mdio_o, mdio_oe, alt_next_page_enable, tx_path_disable;
  logic [15:0] np_tx_word, lp_base_word, event_enable_word, indicator_cfg_word, tx_ctrl_word;
  logic [15:0] m [32];
  logic [4:0] amap [$] = '{5'h12, 5'h14, 5'h1e, 5'h11, 5'h13, 5'h15, 5'h1d, 5'h1f, 5'h05};
  int num_errors = 0, compares = 0;
  logic pdf = 0, prx = 0, bp = 0, base_page = 0;
  always #2 clk = ~clk;
  // wire level: pull-up wins only when nobody drives
  assign mdio_w = mdio_oe ? mdio_o : (h_en ? h_d : 1'b1);
  anp_regs i_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .mdc(mdc), .mdio_i(mdio_w),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .page_rx_stb(page_rx_stb), .page_is_next(page_is_next),
    .rx_code_word(rx_code_word), .pd_fault_stb(pd_fault_stb), .lp_np_able(lp_np_able),
    .lp_an_able(lp_an_able), .base_page(base_page), .mr_page_rx(mr_page_rx),
    .an_tx_disable(an_tx_disable), .tx_word_stb(tx_word_stb), .tx_toggle_sent(tx_toggle_sent),
    .sec_status_in(sec_status_in), .evt_change_in(evt_change_in), .np_tx_word(np_tx_word),
    .lp_base_word(lp_base_word), .alt_next_page_enable(alt_next_page_enable),
    .tx_path_disable(tx_path_disable), .event_enable_word(event_enable_word),
    .indicator_cfg_word(indicator_cfg_word), .tx_ctrl_word(tx_ctrl_word));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // mdc 8 clk low, 8 clk high; host changes mdio while mdc is low
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rdo);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    rdo = 16'h0;
    for (int i = 0; i < 65; i++) begin
      @(posedge clk);
      mdc <= 1'b0;
      h_en <= (i < 46) || (op == `ANP_OP_WR && i < 64);
      h_d <= (i < 64) ? f[63-i] : 1'b1;
      repeat (7) @(posedge clk);
      @(negedge clk);
      if (i >= 48 && i < 64) rdo[63-i] = mdio_w;
      @(posedge clk);
      mdc <= 1'b1;
      repeat (7) @(posedge clk);
    end
    @(posedge clk);
    mdc <= 1'b0;
    h_en <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : frame

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    frame(`ANP_OP_WR, 5'h00, ra, wd, rd);
  endtask : wr

  task automatic rdr(input logic [4:0] ra, input logic [15:0] exp, input string name);
    frame(`ANP_OP_RD, 5'h00, ra, 16'h0, rd);
    chk(name, rd, exp);
  endtask : rdr

  // expansion read model: snapshot, then latched bits fall
  function automatic logic [15:0] exp6();
    exp6 = {10'h0, bp, pdf, lp_np_able, 1'b1, prx, lp_an_able};
    bp = 1'b0;
    pdf = 1'b0;
    prx = 1'b0;
  endfunction : exp6

  task automatic pulse(input int kind, input logic [15:0] w);
    @(posedge clk);
    rx_code_word <= w;
    page_rx_stb <= (kind == 0);
    pd_fault_stb <= (kind == 1);
    tx_word_stb <= (kind == 2);
    base_page <= (kind == 3);
    @(posedge clk);
    base_page <= 1'b0;
    page_rx_stb <= 1'b0;
    pd_fault_stb <= 1'b0;
    tx_word_stb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic summarize();
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial begin
    void'($urandom(32'hf67e));
    foreach (m[k]) m[k] = 16'h0;
    m[7] = `ANP_NPTX_RST;
    m[16] = `ANP_CFG_RST;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdr(`ANP_REG_EXP, exp6(), "expansion");
    rdr(`ANP_REG_NPTX, 16'h2001, "np_tx");
    rdr(`ANP_REG_LPNP, 16'h0000, "lp_np");
    rdr(`ANP_REG_CFG, 16'h0080, "cfg");
    // reserved and toggle bits forced high to prove they do not store
    for (int k = 0; k < 3; k++) begin
      v = 16'($urandom) | 16'h4800;
      wr(`ANP_REG_NPTX, v);
      m[7] = (v & 16'hb7ff) | (m[7] & 16'h0800);
      rdr(`ANP_REG_NPTX, m[7], "np_tx");
      chk("np_tx_word", np_tx_word, m[7]);
    end
    for (int t = 0; t < 2; t++) begin
      tx_toggle_sent <= t[0];
      pulse(2, 16'h0);
      m[7][11] = ~t[0];
      rdr(`ANP_REG_NPTX, m[7], "toggle");
    end
    for (int k = 0; k < 4; k++) begin
      v = 16'($urandom);
      lp_np_able <= v[0];
      lp_an_able <= v[1];
      page_is_next <= v[2];
      if (v[3]) pulse(1, v);
      pdf = pdf | v[3];
      pulse(3, v);
      pulse(0, v);
      prx = 1'b1;
      if (v[2]) m[8] = v;
      else chk("lp_base_word", lp_base_word, v);
      rdr(`ANP_REG_LPNP, m[8], "lp_np");
      rdr(`ANP_REG_EXP, exp6(), "expansion");
      rdr(`ANP_REG_EXP, exp6(), "expansion cleared");
    end
    wr(`ANP_REG_CFG, 16'h0002);
    chk("alt", {15'h0, alt_next_page_enable}, 16'h0001);
    pulse(0, 16'h0);
    mr_page_rx <= 1'b0;
    rdr(`ANP_REG_EXP, exp6(), "alt page_rx clear");
    mr_page_rx <= 1'b1;
    pulse(0, 16'h0);
    an_tx_disable <= 1'b1;
    rdr(`ANP_REG_EXP, exp6(), "alt tx_disable clear");
    an_tx_disable <= 1'b0;
    pulse(3, 16'h0);
    bp = 1'b1;
    rdr(`ANP_REG_EXP, exp6(), "alt base page");
    rdr(`ANP_REG_EXP, exp6(), "alt base page cleared");
    v = 16'($urandom);
    wr(`ANP_REG_CFG, v);
    m[16] = v & `ANP_CFG_WMASK;
    rdr(`ANP_REG_CFG, m[16], "cfg");
    chk("cfg outputs", {14'h0, tx_path_disable, alt_next_page_enable},
      {14'h0, m[16][13], m[16][1]});
    foreach (amap[k]) begin
      v = 16'($urandom);
      sec_status_in <= ~v;
      evt_change_in <= v ^ 16'h5a5a;
      wr(amap[k], v);
      if (amap[k] inside {5'h12, 5'h14, 5'h1e}) m[amap[k]] = v;
      e = m[amap[k]];
      if (amap[k] == 5'h11) e = ~v;
      if (amap[k] == 5'h13) e = v ^ 16'h5a5a;
      if (amap[k] == 5'h05) e = 16'hffff;
      rdr(amap[k], e, "address map");
    end
    chk("event_enable_word", event_enable_word, m[18]);
    chk("indicator_cfg_word", indicator_cfg_word, m[20]);
    chk("tx_ctrl_word", tx_ctrl_word, m[30]);
    frame(`ANP_OP_RD, 5'h03, `ANP_REG_NPTX, 16'h0, rd);
    chk("other phy", rd, 16'hffff);
    summarize();
  end
endmodule : autoneg_next_page_regs_test
